//--- src/rtcrm_register_bank.sv
// register bank of the calendar clock: byte access, bcd time counters, charge gate
`timescale 1ns/1ps
// Operation
// - time counters (seconds, minutes, hours) held in bcd; date registers do not count
// - other registers plain binary or flag bits
// - unimplemented bits read back as zero
// - one designated bit reads undefined value
// - sixteen registers at consecutive addresses
// - no backup charging while enable low
// - address pointer increments after each byte
// - time counters frozen during register access
module rtcrm_register_bank
  import rtcrm_pkg::*;
#(
  parameter logic UNDEF_BIT_VALUE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input rtcrm_access_t host_access,
  input wire logic second_tick,
  input wire logic charge_enable_pin,
  input wire logic supply_valid_pin,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic [3:0] address_pointer,
  output logic charge_pump_on,
  output logic clock_stopped
);
  logic [15:0][7:0] regs_reg;
  logic [15:0][7:0] regs_next;
  logic [3:0] ptr_reg;
  logic [3:0] ptr_next;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [3:0] raddr_reg;
  logic pend_reg;
  logic en_meta_reg;
  logic en_sync_reg;
  logic ok_meta_reg;
  logic ok_sync_reg;
  logic charge_reg;

  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] max);
    logic [8:0] r;
    r = 9'h000;
    if (v >= max) begin
      r = 9'h100;
    end else if (v[3:0] >= 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : bcd_inc

  // byte addressing
  // sixteen byte locations
  wire [3:0] byte_addr = host_access.start ? host_access.addr : ptr_reg;
  wire byte_wr = host_access.valid & host_access.write;
  wire byte_rd = host_access.valid & ~host_access.write;
  wire stop_bit = regs_reg[RTCRM_OFF_CONTROL_PRIMARY][RTCRM_BIT_CLOCK_STOP];
  wire tick_apply = (pend_reg | second_tick) & ~host_access.active & ~stop_bit;
  wire [8:0] sec_inc = bcd_inc({1'b0, regs_reg[RTCRM_OFF_SECONDS][6:0]}, RTCRM_BCD_MAX_SECONDS);
  wire [8:0] min_inc = bcd_inc({1'b0, regs_reg[RTCRM_OFF_MINUTES][6:0]}, RTCRM_BCD_MAX_MINUTES);
  wire [8:0] hr_inc = bcd_inc({2'b00, regs_reg[RTCRM_OFF_HOURS][5:0]}, RTCRM_BCD_MAX_HOURS);
  wire [7:0] read_masked = regs_reg[byte_addr] & RTCRM_IMPL_MASK[byte_addr];
  wire [7:0] undef_fill = (byte_addr == RTCRM_UNDEF_REG) ? (8'({UNDEF_BIT_VALUE}) << RTCRM_UNDEF_BIT) : 8'h00;

  always_comb begin
    regs_next = regs_reg;
    if (tick_apply) begin
      regs_next[RTCRM_OFF_SECONDS][6:0] = sec_inc[6:0];
      if (sec_inc[8]) begin
        regs_next[RTCRM_OFF_MINUTES][6:0] = min_inc[6:0];
        if (min_inc[8]) begin
          regs_next[RTCRM_OFF_HOURS][5:0] = hr_inc[5:0];
        end
      end
    end
    if (byte_wr) begin
      regs_next[byte_addr] = host_access.wdata & RTCRM_IMPL_MASK[byte_addr];
    end
  end

  assign ptr_next = host_access.valid ? byte_addr + 4'h1 : (host_access.start ? host_access.addr : ptr_reg);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regs_reg <= RTCRM_RESET_VAL;
      ptr_reg <= 4'h0;
      pend_reg <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      ptr_reg <= ptr_next;
      pend_reg <= (pend_reg | second_tick) & ~tick_apply & ~stop_bit;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      raddr_reg <= 4'h0;
    end else begin
      rvalid_reg <= byte_rd;
      if (byte_rd) begin
        rdata_reg <= read_masked | undef_fill;
        raddr_reg <= byte_addr;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
      ok_meta_reg <= 1'b0;
      ok_sync_reg <= 1'b0;
      charge_reg <= 1'b0;
    end else begin
      en_meta_reg <= charge_enable_pin;
      en_sync_reg <= en_meta_reg;
      ok_meta_reg <= supply_valid_pin;
      ok_sync_reg <= ok_meta_reg;
      charge_reg <= en_sync_reg & ok_sync_reg;
    end
  end

  assign read_data = rdata_reg;
  assign read_valid = rvalid_reg;
  assign address_pointer = ptr_reg;
  assign charge_pump_on = charge_reg;
  assign clock_stopped = stop_bit;

  wire [7:0] rd_mask_chk = RTCRM_IMPL_MASK[raddr_reg] |
    ((raddr_reg == RTCRM_UNDEF_REG) ? 8'h80 : 8'h00);
  wire time_written = byte_wr && (byte_addr >= RTCRM_OFF_SECONDS) && (byte_addr <= RTCRM_OFF_HOURS);

  property p_unimpl_zero;
    @(posedge sys_clk) disable iff (sys_rst) read_valid |-> ((read_data & ~rd_mask_chk) == 8'h00);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read nonzero");

  property p_write_masked;
    @(posedge sys_clk) disable iff (sys_rst)
      (byte_wr && !tick_apply) |=> (regs_reg[$past(byte_addr)] == ($past(host_access.wdata) & RTCRM_IMPL_MASK[$past(byte_addr)]));
  endproperty
  a_write_masked: assert property (p_write_masked) else $error("write not masked to implemented bits");

  property p_ptr_inc;
    @(posedge sys_clk) disable iff (sys_rst) host_access.valid |=> ptr_reg == 4'($past(byte_addr) + 4'h1);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");

  property p_freeze;
    @(posedge sys_clk) disable iff (sys_rst)
      (host_access.active && !time_written) |=> $stable(regs_reg[RTCRM_OFF_SECONDS][6:0]) && $stable(regs_reg[RTCRM_OFF_MINUTES]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("time advanced during access");

  property p_charge_off;
    @(posedge sys_clk) disable iff (sys_rst) !en_sync_reg |=> !charge_pump_on;
  endproperty
  a_charge_off: assert property (p_charge_off) else $error("charging with enable low");

  property p_charge_on;
    @(posedge sys_clk) disable iff (sys_rst) (en_sync_reg && ok_sync_reg) [*2] |-> charge_pump_on;
  endproperty
  a_charge_on: assert property (p_charge_on) else $error("no charging with enable high");

  property p_bcd_wrap;
    @(posedge sys_clk) disable iff (sys_rst)
      (tick_apply && !byte_wr && regs_reg[RTCRM_OFF_SECONDS][6:0] == 7'h59) |=> regs_reg[RTCRM_OFF_SECONDS][6:0] == 7'h00;
  endproperty
  a_bcd_wrap: assert property (p_bcd_wrap) else $error("seconds did not wrap in bcd");

  property p_bcd_digit;
    @(posedge sys_clk) disable iff (sys_rst)
      (tick_apply && !byte_wr && regs_reg[RTCRM_OFF_SECONDS][3:0] == 4'h9 && regs_reg[RTCRM_OFF_SECONDS][6:4] < 3'h5)
      |=> regs_reg[RTCRM_OFF_SECONDS][3:0] == 4'h0;
  endproperty
  a_bcd_digit: assert property (p_bcd_digit) else $error("seconds digit above nine");

  property p_read_latency;
    @(posedge sys_clk) disable iff (sys_rst) byte_rd |=> read_valid ##1 !$past(byte_rd) || read_valid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer late");

  property p_read_data;
    @(posedge sys_clk) disable iff (sys_rst)
      byte_rd
      |=> (read_data & RTCRM_IMPL_MASK[raddr_reg]) == $past(regs_reg[byte_addr] & RTCRM_IMPL_MASK[byte_addr]);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data differs from register");

  property p_undef_fill;
    @(posedge sys_clk) disable iff (sys_rst)
      read_valid && raddr_reg == RTCRM_UNDEF_REG
      |-> read_data[RTCRM_UNDEF_BIT] == UNDEF_BIT_VALUE;
  endproperty
  a_undef_fill: assert property (p_undef_fill) else $error("undefined bit not the chosen value");

  property p_trim_binary;
    @(posedge sys_clk) disable iff (sys_rst)
      byte_wr && byte_addr == RTCRM_OFF_FREQUENCY_TRIM
      |=> regs_reg[RTCRM_OFF_FREQUENCY_TRIM] == $past(host_access.wdata);
  endproperty
  a_trim_binary: assert property (p_trim_binary) else $error("trim byte not stored as written");

  property p_countdown_static;
    @(posedge sys_clk) disable iff (sys_rst)
      !byte_wr
      |=> $stable(regs_reg[RTCRM_OFF_COUNTDOWN_VALUE]);
  endproperty
  a_countdown_static: assert property (p_countdown_static) else $error("countdown byte changed unwritten");

  property p_ptr_wrap;
    @(posedge sys_clk) disable iff (sys_rst)
      host_access.valid && byte_addr == 4'hf
      |=> ptr_reg == 4'h0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap to zero");

  property p_ptr_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      !host_access.valid && !host_access.start
      |=> $stable(ptr_reg);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved while idle");

  property p_tick_pending;
    @(posedge sys_clk) disable iff (sys_rst)
      second_tick && host_access.active && !stop_bit
      |=> pend_reg;
  endproperty
  a_tick_pending: assert property (p_tick_pending) else $error("tick during access lost");

  property p_pend_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      pend_reg && !host_access.active && !stop_bit
      |=> !pend_reg;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending tick not applied");

  property p_freeze_hours;
    @(posedge sys_clk) disable iff (sys_rst)
      host_access.active && !time_written
      |=> $stable(regs_reg[RTCRM_OFF_HOURS]);
  endproperty
  a_freeze_hours: assert property (p_freeze_hours) else $error("hours advanced during access");

  property p_stop_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      stop_bit && !byte_wr
      |=> $stable(regs_reg[RTCRM_OFF_SECONDS]);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("seconds advanced while stopped");

  property p_min_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      tick_apply && !byte_wr && regs_reg[RTCRM_OFF_SECONDS][6:0] < 7'h59
      |=> $stable(regs_reg[RTCRM_OFF_MINUTES]);
  endproperty
  a_min_hold: assert property (p_min_hold) else $error("minutes moved without carry");

  property p_hour_wrap;
    @(posedge sys_clk) disable iff (sys_rst)
      tick_apply && !byte_wr && regs_reg[RTCRM_OFF_SECONDS][6:0] == 7'h59
        && regs_reg[RTCRM_OFF_MINUTES][6:0] == 7'h59 && regs_reg[RTCRM_OFF_HOURS][5:0] == 6'h23
      |=> regs_reg[RTCRM_OFF_HOURS][5:0] == 6'h00;
  endproperty
  a_hour_wrap: assert property (p_hour_wrap) else $error("hours did not wrap in bcd");

  property p_days_static;
    @(posedge sys_clk) disable iff (sys_rst)
      !byte_wr
      |=> $stable(regs_reg[RTCRM_OFF_DAYS]);
  endproperty
  a_days_static: assert property (p_days_static) else $error("days changed unwritten");

  property p_charge_supply;
    @(posedge sys_clk) disable iff (sys_rst)
      !ok_sync_reg
      |=> !charge_pump_on;
  endproperty
  a_charge_supply: assert property (p_charge_supply) else $error("charging without valid supply");

  property p_read_pulse;
    @(posedge sys_clk) disable iff (sys_rst)
      !byte_rd
      |=> !read_valid;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read answer without read");

  property p_read_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      !byte_rd
      |=> $stable(read_data);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data changed without read");

  c_burst_read: cover property (@(posedge sys_clk) disable iff (sys_rst) byte_rd ##1 byte_rd ##1 byte_rd);
  c_pointer_wrap: cover property (@(posedge sys_clk) disable iff (sys_rst) host_access.valid && byte_addr == 4'hf);
  c_tick_deferred: cover property (@(posedge sys_clk) disable iff (sys_rst) second_tick && host_access.active ##[1:20] tick_apply);
  c_charging: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(charge_pump_on));
  c_hour_wrap: cover property (@(posedge sys_clk) disable iff (sys_rst)
    tick_apply && regs_reg[RTCRM_OFF_HOURS][5:0] == 6'h23 && regs_reg[RTCRM_OFF_MINUTES][6:0] == 7'h59);
endmodule : rtcrm_register_bank

//--- src/rtcrm_pkg.sv
// package: register map, field layout and reset values for the calendar register bank
package rtcrm_pkg;
  localparam int RTCRM_NUM_REGS = 16;
  localparam logic [3:0] RTCRM_OFF_CONTROL_PRIMARY = 4'h0;
  localparam logic [3:0] RTCRM_OFF_CONTROL_FLAGS_SECONDARY = 4'h1;
  localparam logic [3:0] RTCRM_OFF_SECONDS = 4'h2;
  localparam logic [3:0] RTCRM_OFF_MINUTES = 4'h3;
  localparam logic [3:0] RTCRM_OFF_HOURS = 4'h4;
  localparam logic [3:0] RTCRM_OFF_DAYS = 4'h5;
  localparam logic [3:0] RTCRM_OFF_WEEKDAYS = 4'h6;
  localparam logic [3:0] RTCRM_OFF_MONTHS = 4'h7;
  localparam logic [3:0] RTCRM_OFF_YEARS = 4'h8;
  localparam logic [3:0] RTCRM_OFF_ALARM_MINUTE = 4'h9;
  localparam logic [3:0] RTCRM_OFF_ALARM_HOUR = 4'ha;
  localparam logic [3:0] RTCRM_OFF_ALARM_DAY = 4'hb;
  localparam logic [3:0] RTCRM_OFF_ALARM_WEEKDAY = 4'hc;
  localparam logic [3:0] RTCRM_OFF_FREQUENCY_TRIM = 4'hd;
  localparam logic [3:0] RTCRM_OFF_CLOCK_OUTPUT_TIMER_CONFIG = 4'he;
  localparam logic [3:0] RTCRM_OFF_COUNTDOWN_VALUE = 4'hf;
  // field positions
  localparam int RTCRM_BIT_EXTERNAL_CLOCK_TEST_MODE = 7;
  localparam int RTCRM_BIT_CLOCK_STOP = 5;
  localparam int RTCRM_BIT_SOFT_RESET_TRIGGER = 4;
  localparam int RTCRM_BIT_HOUR_MODE_12 = 2;
  localparam int RTCRM_BIT_OSCILLATOR_STOPPED_FLAG = 7;
  localparam logic [7:0] RTCRM_BCD_MAX_SECONDS = 8'h59;
  localparam logic [7:0] RTCRM_BCD_MAX_MINUTES = 8'h59;
  localparam logic [7:0] RTCRM_BCD_MAX_HOURS = 8'h23;
  // the one position whose read value is undefined: minutes bit 7
  localparam logic [3:0] RTCRM_UNDEF_REG = 4'h3;
  localparam int RTCRM_UNDEF_BIT = 7;
  // implemented bits per register, index = offset
  localparam logic [15:0][7:0] RTCRM_IMPL_MASK = '{
    8'hff, 8'h7b, 8'hff, 8'h87, 8'hbf, 8'hbf, 8'hff, 8'hff,
    8'h1f, 8'h07, 8'h3f, 8'h3f, 8'h7f, 8'hff, 8'hff, 8'hb6};
  // values after reset, index = offset
  localparam logic [15:0][7:0] RTCRM_RESET_VAL = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
  typedef struct packed {
    logic active;
    logic start;
    logic valid;
    logic write;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtcrm_access_t;
endpackage : rtcrm_pkg

//--- verification/rtcrm_host_model.sv
// host model: drives the byte access port of the register bank
`timescale 1ns/1ps
module rtcrm_host_model
  import rtcrm_pkg::*;
(
  input wire logic sys_clk,
  output rtcrm_access_t host_access,
  input wire logic [7:0] read_data,
  input wire logic read_valid
);
  initial host_access = '0;
  function automatic logic [7:0] clean(input logic [3:0] a, input logic [7:0] d);
    clean = (a == RTCRM_OFF_CONTROL_PRIMARY) ? (d & 8'hb6) : d;
  endfunction : clean
  task automatic xfer(input logic st, input logic [3:0] a, input logic wr, input logic [7:0] d,
                      output logic [8:0] q);
    @(posedge sys_clk);
    host_access <= '{active: 1'b1, start: st, valid: 1'b1, write: wr, addr: a, wdata: clean(a, d)};
    @(posedge sys_clk);
    host_access.start <= 1'b0;
    host_access.valid <= 1'b0;
    host_access.addr <= ~a;
    host_access.wdata <= ~d;
    #1 q = {read_valid, read_data};
  endtask : xfer
  task automatic release_bus();
    @(posedge sys_clk);
    host_access.active <= 1'b0;
  endtask : release_bus
endmodule : rtcrm_host_model

//--- verification/testbench.sv
// testbench: reset values, register map, bcd counting, freeze and charge gate
`timescale 1ns/1ps
module testbench
  import rtcrm_pkg::*;
;
  logic sys_clk;
  logic sys_rst;
  logic second_tick;
  logic charge_enable_pin;
  logic supply_valid_pin;
  rtcrm_access_t host_access;
  logic [7:0] read_data;
  logic read_valid;
  logic [3:0] address_pointer;
  logic charge_pump_on;
  logic clock_stopped;
  int error_cnt;
  int comparisons;
  rtcrm_register_bank #(.UNDEF_BIT_VALUE(1'b1)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .host_access(host_access), .second_tick(second_tick), .charge_enable_pin(charge_enable_pin),
    .supply_valid_pin(supply_valid_pin), .read_data(read_data), .read_valid(read_valid),
    .address_pointer(address_pointer), .charge_pump_on(charge_pump_on), .clock_stopped(clock_stopped));
  rtcrm_host_model host (.sys_clk(sys_clk), .host_access(host_access), .read_data(read_data),
    .read_valid(read_valid));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [3:0] a, input logic st, input logic [7:0] exp);
    logic [8:0] q;
    logic [7:0] um;
    um = (a == RTCRM_UNDEF_REG) ? ~(8'h01 << RTCRM_UNDEF_BIT) : 8'hff;
    host.xfer(st, a, 1'b0, 8'h00, q);
    check("read", {q[8], q[7:0] & um}, {1'b1, exp & RTCRM_IMPL_MASK[a] & um});
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic st, input logic [7:0] d);
    logic [8:0] q;
    host.xfer(st, a, 1'b1, d, q);
    check("write answer", {8'h00, q[8]}, 9'h000);
  endtask : wr
  task automatic tick();
    @(posedge sys_clk);
    second_tick <= 1'b1;
    @(posedge sys_clk);
    second_tick <= 1'b0;
  endtask : tick
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    sys_rst = 1'b1;
    second_tick = 1'b0;
    charge_enable_pin = 1'b0;
    supply_valid_pin = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < RTCRM_NUM_REGS; i++) rd(i[3:0], i == 0, RTCRM_RESET_VAL[i]);
    host.release_bus();
    check("pointer", {5'h00, address_pointer}, 9'h000);
    for (int i = 0; i < RTCRM_NUM_REGS; i++) wr(i[3:0], i == 0, 8'hff);
    host.release_bus();
    check("stop level", {8'h00, clock_stopped}, 9'h001);
    for (int i = 0; i < RTCRM_NUM_REGS; i++) rd(i[3:0], 1'b1, 8'hff);
    wr(RTCRM_OFF_CONTROL_PRIMARY, 1'b1, 8'h00);
    wr(RTCRM_OFF_SECONDS, 1'b1, 8'h59);
    wr(RTCRM_OFF_MINUTES, 1'b0, 8'h59);
    wr(RTCRM_OFF_HOURS, 1'b0, 8'h23);
    host.release_bus();
    tick();
    rd(RTCRM_OFF_SECONDS, 1'b1, 8'h00);
    rd(RTCRM_OFF_MINUTES, 1'b0, 8'h00);
    rd(RTCRM_OFF_HOURS, 1'b0, 8'h00);
    rd(RTCRM_OFF_DAYS, 1'b0, 8'hff);
    wr(RTCRM_OFF_SECONDS, 1'b1, 8'h09);
    tick();
    rd(RTCRM_OFF_SECONDS, 1'b1, 8'h09);
    host.release_bus();
    repeat (3) @(posedge sys_clk);
    rd(RTCRM_OFF_SECONDS, 1'b1, 8'h10);
    host.release_bus();
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      charge_enable_pin <= i[0];
      supply_valid_pin <= i[1];
      repeat (4) @(posedge sys_clk);
      #1 check("charge", {8'h00, charge_pump_on}, {8'h00, i[0] & i[1]});
    end
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 check("pointer after reset", {5'h00, address_pointer}, 9'h000);
    check("stop after reset", {8'h00, clock_stopped}, 9'h000);
    rd(RTCRM_OFF_SECONDS, 1'b1, RTCRM_RESET_VAL[RTCRM_OFF_SECONDS]);
    rd(RTCRM_OFF_MINUTES, 1'b0, RTCRM_RESET_VAL[RTCRM_OFF_MINUTES]);
    host.release_bus();
    wrap_up();
  end
endmodule : testbench
